// File: verilog/iou_datapath.v
// gyro and accelerometer output unit datapath with apb control registers
// assumes one internal sample strobe per 2000 Hz tick and a latch strobe
// per transmitted datagram, both one cycle wide and synchronous to sys_clk
//
// Behaviour
// - incremental angle is the per-transmission angle sum, 24 bits, lsb 2^-21 deg.
// - each 24-bit field leaves as high, middle and low bytes of the value.
// - average rate is the mean of the internal samples since the last latch.
// - the gyro low-pass filter acts on the samples before they are averaged.
// - average rate uses the same 24-bit scaling as plain angular rate.
// - angular rate is 24-bit two's complement with lsb 2^-14 deg/s.
// - integrated angle runs from reset and wraps within [-4, 4) deg silently.
// - integrated angle uses the incremental angle scaling, lsb 2^-21 deg.
// - gyro bias and scale factor can each be corrected from measured g.
// - a switchable one-pole low-pass filters the g signal before correction.
// - the g filter corner is 0.001 Hz, 0.01 Hz or 5 Hz.
// - acceleration field scaling divisor is 2^21, 2^20, 2^19, 2^18, 2^16 by range.
// - velocity increment divisor is 2^24, 2^23, 2^22, 2^21, 2^19 by range.
`timescale 1ns/1ps
`include "iou_map.vh"
module iou_datapath #(
    parameter SW = 24,
    parameter CNTW = 12
) (
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // apb slave
    input wire [11:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // internal samples
    input wire sampleStrobe,
    input wire [SW-1:0] gyroSample,
    input wire [SW-1:0] accelSample,
    input wire [SW-1:0] inclSample,
    input wire latchStrobe,
    // datagram fields
    output wire fieldValid,
    input wire fieldReady,
    output wire [7:0] gyroFieldByteHi,
    output wire [7:0] gyroFieldByteMid,
    output wire [7:0] gyroFieldByteLo,
    output wire [7:0] accelFieldByteHi,
    output wire [7:0] accelFieldByteMid,
    output wire [7:0] accelFieldByteLo
);

    localparam SUMW = SW + CNTW;
    localparam FW = 2 * SW;
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_DIV = 3'b010;
    localparam [2:0] ST_PUSH = 3'b100;
    localparam [CNTW-1:0] CNT_ONE = 1;

    // saturate a wide signed value into a 24-bit field
    function [SW-1:0] sat;
        input signed [63:0] v;
        reg signed [63:0] lim;
        begin
            lim = 64'sh0000_0000_007F_FFFF;
            if (v > lim)
                sat = {1'b0, {(SW-1){1'b1}}};
            else if (v < -lim - 64'sh1)
                sat = {1'b1, {(SW-1){1'b0}}};
            else
                sat = v[SW-1:0];
        end
    endfunction

    //**************************************************************
    // register file
    //**************************************************************
    reg [31:0] ctrlReg;
    reg [15:0] biasKReg;
    reg [15:0] scaleKReg;
    reg overrunReg;
    reg [2:0] stateReg;
    wire bufReady;
    wire setupPhase;
    wire wrAccess;
    wire addrHit;
    wire overrunSet;
    wire [31:0] byteMask;
    reg [31:0] readMux;
    reg [SW+15:0] integReg;

    assign setupPhase = psel && !penable;
    assign wrAccess = psel && penable && pready && pwrite;
    assign addrHit = (paddr == `IOU_OFS_CTRL) || (paddr == `IOU_OFS_BIASK) ||
        (paddr == `IOU_OFS_SCALEK) || (paddr == `IOU_OFS_STATUS) ||
        (paddr == `IOU_OFS_INTEG);
    assign byteMask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}},
        {8{pstrb[0]}}};

    // read data is chosen in the setup cycle so prdata is a flop output
    always @*
    begin
        readMux = 32'h0000_0000;
        case (paddr)
            `IOU_OFS_CTRL: readMux = ctrlReg;
            `IOU_OFS_BIASK: readMux = {16'h0000, biasKReg};
            `IOU_OFS_SCALEK: readMux = {16'h0000, scaleKReg};
            `IOU_OFS_STATUS:
            begin
                readMux[`IOU_S_OVR] = overrunReg;
                readMux[`IOU_S_BUSY] = !stateReg[0];
                readMux[`IOU_S_FULL] = !bufReady;
            end
            `IOU_OFS_INTEG: readMux = {8'h00, integReg[SW+15:16]};
            default: readMux = 32'h0000_0000;
        endcase
    end

    // zero-wait slave: pready rises after reset and stays high
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            ctrlReg <= `IOU_CTRL_RST;
            biasKReg <= `IOU_COEF_RST;
            scaleKReg <= `IOU_COEF_RST;
        end
        else
        begin
            pready <= 1'b1;
            if (setupPhase)
            begin
                prdata <= readMux;
                pslverr <= !addrHit;
            end
            if (wrAccess && paddr == `IOU_OFS_CTRL)
                ctrlReg <= ((ctrlReg & ~byteMask) | (pwdata & byteMask)) &
                    `IOU_CTRL_MASK;
            if (wrAccess && paddr == `IOU_OFS_BIASK)
                biasKReg <= (biasKReg & ~byteMask[15:0]) |
                    (pwdata[15:0] & byteMask[15:0]);
            if (wrAccess && paddr == `IOU_OFS_SCALEK)
                scaleKReg <= (scaleKReg & ~byteMask[15:0]) |
                    (pwdata[15:0] & byteMask[15:0]);
        end
    end

    // overrun is sticky; a new overrun beats a write-one clear
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            overrunReg <= 1'b0;
        else if (overrunSet)
            overrunReg <= 1'b1;
        else if (wrAccess && paddr == `IOU_OFS_STATUS && pstrb[0] &&
            pwdata[`IOU_S_OVR])
            overrunReg <= 1'b0;
    end

    //**************************************************************
    // g-compensation and gyro filtering
    //**************************************************************
    wire signed [SW-1:0] gyroIn = gyroSample;
    wire signed [SW-1:0] compSrc = ctrlReg[`IOU_F_CSRC] ? inclSample :
        accelSample;
    reg signed [FW-1:0] cfStateReg;
    reg signed [FW-1:0] glStateReg;
    reg [4:0] cfShift;
    wire signed [FW-1:0] cfNext;
    wire signed [FW-1:0] glNext;
    wire signed [SW-1:0] gFilt;
    wire signed [FW-1:0] biasProd;
    wire signed [FW-1:0] rateXg;
    wire signed [FW-1:0] scaleProd;
    wire signed [SW+1:0] compWide;
    wire signed [SW-1:0] compRate;
    wire signed [SW-1:0] procRate;

    // corner selects the coefficient shift, alpha near 2*pi*fc/2000
    always @*
    begin
        case (ctrlReg[`IOU_F_CORNER])
            `IOU_FC_0P001: cfShift = `IOU_SH_0P001;
            `IOU_FC_0P01: cfShift = `IOU_SH_0P01;
            `IOU_FC_5HZ: cfShift = `IOU_SH_5HZ;
            default: cfShift = `IOU_SH_5HZ;
        endcase
    end

    // one-pole filters: y += (x - y) * 2^-shift, kept with 24 fraction bits
    assign cfNext = cfStateReg +
        (($signed({compSrc, {SW{1'b0}}}) - cfStateReg) >>> cfShift);
    assign gFilt = ctrlReg[`IOU_F_CFEN] ? cfStateReg[FW-1:SW] : compSrc;

    // bias term is g times coefficient; scale term is rate times g times k
    assign biasProd = ctrlReg[`IOU_F_BIASEN] ?
        (gFilt * $signed(biasKReg)) >>> `IOU_COEF_FRAC :
        $signed({FW{1'b0}});
    assign rateXg = (gyroIn * gFilt) >>> `IOU_RXA_FRAC;
    assign scaleProd = ctrlReg[`IOU_F_SCALEEN] ?
        ($signed(rateXg[SW-1:0]) * $signed(scaleKReg)) >>> `IOU_COEF_FRAC :
        $signed({FW{1'b0}});
    assign compWide = {{2{gyroIn[SW-1]}}, gyroIn} - biasProd[SW+1:0] -
        scaleProd[SW+1:0];
    assign compRate = sat({{(64-SW-2){compWide[SW+1]}}, compWide});

    // gyro filter runs ahead of the averaging sum
    assign glNext = glStateReg + (($signed({compRate, {SW{1'b0}}}) -
        glStateReg) >>> ctrlReg[`IOU_F_GLPFSH]);
    assign procRate = ctrlReg[`IOU_F_GLPFEN] ? glNext[FW-1:SW] :
        compRate;

    //**************************************************************
    // accumulation between latches
    //**************************************************************
    reg signed [SUMW-1:0] gyroSumReg;
    reg signed [SUMW-1:0] accSumReg;
    reg [CNTW-1:0] countReg;
    reg signed [SW-1:0] lastRateReg;
    reg signed [SW-1:0] lastAccReg;
    wire signed [SW+16:0] angleStep;
    wire signed [SUMW-1:0] rateExt;
    wire signed [SUMW-1:0] accExt;

    assign angleStep = procRate * $signed(`IOU_K_ANGLE);
    assign rateExt = {{CNTW{procRate[SW-1]}}, procRate};
    assign accExt = {{CNTW{accelSample[SW-1]}}, accelSample};

    // a sample in the latch cycle opens the new period
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfStateReg <= {FW{1'b0}};
            glStateReg <= {FW{1'b0}};
            gyroSumReg <= {SUMW{1'b0}};
            accSumReg <= {SUMW{1'b0}};
            countReg <= {CNTW{1'b0}};
            lastRateReg <= {SW{1'b0}};
            lastAccReg <= {SW{1'b0}};
            integReg <= {(SW+16){1'b0}};
        end
        else
        begin
            if (sampleStrobe)
            begin
                cfStateReg <= cfNext;
                glStateReg <= glNext;
                lastRateReg <= procRate;
                lastAccReg <= accelSample;
                // wraps in 24 integer bits, no flag raised
                integReg <= integReg +
                    angleStep[SW+15:0];
            end
            if (latchStrobe)
            begin
                gyroSumReg <= sampleStrobe ? rateExt : {SUMW{1'b0}};
                accSumReg <= sampleStrobe ? accExt : {SUMW{1'b0}};
                countReg <= sampleStrobe ? CNT_ONE : {CNTW{1'b0}};
            end
            else if (sampleStrobe)
            begin
                gyroSumReg <= gyroSumReg + rateExt;
                accSumReg <= accSumReg + accExt;
                countReg <= countReg + CNT_ONE;
            end
        end
    end

    //**************************************************************
    // field formation and hand-off
    //**************************************************************
    reg signed [SUMW-1:0] snapGyroReg;
    reg signed [SUMW-1:0] snapAccReg;
    reg [CNTW-1:0] snapCntReg;
    reg signed [SW-1:0] snapRateReg;
    reg signed [SW-1:0] snapAccelReg;
    reg [SW-1:0] snapIntegReg;
    reg divStartReg;
    reg [FW-1:0] resultReg;
    reg [SW-1:0] gyroField;
    reg [SW-1:0] accelField;
    reg [2:0] velShift;
    wire divBusy;
    wire divDone;
    wire [SUMW-1:0] divQuot;
    wire [SUMW-1:0] gyroMag;
    wire signed [SUMW-1:0] avgSigned;
    wire signed [SUMW+16:0] incrAngle;
    wire signed [SUMW+16:0] incrVel;
    wire [FW-1:0] bufOut;

    assign overrunSet = latchStrobe && !stateReg[0];
    assign gyroMag = snapGyroReg[SUMW-1] ? -snapGyroReg : snapGyroReg;
    assign avgSigned = snapGyroReg[SUMW-1] ? -divQuot : divQuot;
    assign incrAngle = (snapGyroReg * $signed(`IOU_K_ANGLE)) >>>
        `IOU_K_FRAC;
    assign incrVel = (snapAccReg * $signed(`IOU_K_VEL)) >>>
        `IOU_K_FRAC;

    // the mean needs a division since 2000/rate is not always a power of two
    iou_divider #(
        .NW(SUMW),
        .DW(CNTW)
    ) uDiv (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .start(divStartReg),
        .numer(gyroMag),
        .denom(snapCntReg),
        .busy(divBusy),
        .done(divDone),
        .quot(divQuot)
    );

    // per-range shift for velocity; acceleration takes one more
    always @*
    begin
        case (ctrlReg[`IOU_F_RANGE])
            `IOU_RNG_2G: velShift = `IOU_VSH_2G;
            `IOU_RNG_5G: velShift = `IOU_VSH_5G;
            `IOU_RNG_10G: velShift = `IOU_VSH_10G;
            `IOU_RNG_30G: velShift = `IOU_VSH_30G;
            `IOU_RNG_80G: velShift = `IOU_VSH_80G;
            default: velShift = `IOU_VSH_2G;
        endcase
    end

    // unit selection for each field; an empty period averages to last rate
    always @*
    begin
        case (ctrlReg[`IOU_F_GUNIT])
            `IOU_GU_RATE: gyroField = snapRateReg;
            `IOU_GU_INCR: gyroField = sat(incrAngle);
            `IOU_GU_AVG: gyroField = (snapCntReg == {CNTW{1'b0}}) ?
                snapRateReg : sat(avgSigned);
            `IOU_GU_INTEG: gyroField = snapIntegReg;
            default: gyroField = snapRateReg;
        endcase
        if (ctrlReg[`IOU_F_AUNIT] == `IOU_AU_VEL)
            accelField = sat(incrVel >>> velShift);
        else
            accelField = sat(snapAccelReg >>>
                (velShift + `IOU_ASH_EXTRA));
    end

    // idle takes a latch, div waits for the mean, push waits for room
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stateReg <= ST_IDLE;
            snapGyroReg <= {SUMW{1'b0}};
            snapAccReg <= {SUMW{1'b0}};
            snapCntReg <= {CNTW{1'b0}};
            snapRateReg <= {SW{1'b0}};
            snapAccelReg <= {SW{1'b0}};
            snapIntegReg <= {SW{1'b0}};
            divStartReg <= 1'b0;
            resultReg <= {FW{1'b0}};
        end
        else
        begin
            divStartReg <= 1'b0;
            case (stateReg)
                ST_IDLE:
                    if (latchStrobe)
                    begin
                        snapGyroReg <= gyroSumReg;
                        snapAccReg <= accSumReg;
                        snapCntReg <= countReg;
                        snapRateReg <= lastRateReg;
                        snapAccelReg <= lastAccReg;
                        snapIntegReg <= integReg[SW+15:16];
                        divStartReg <= 1'b1;
                        stateReg <= ST_DIV;
                    end
                ST_DIV:
                    if (divDone)
                    begin
                        resultReg <= {gyroField, accelField};
                        stateReg <= ST_PUSH;
                    end
                ST_PUSH:
                    if (bufReady)
                        stateReg <= ST_IDLE;
                default: stateReg <= ST_IDLE;
            endcase
        end
    end

    // a stalled receiver backs up into the push state, not into lost words
    iou_pair_buffer #(
        .W(FW)
    ) uBuf (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .inValid(stateReg[2]),
        .inReady(bufReady),
        .inData(resultReg),
        .outValid(fieldValid),
        .outReady(fieldReady),
        .outData(bufOut)
    );

    // byte split: value = hi * 65536 + mid * 256 + lo
    assign gyroFieldByteHi = bufOut[47:40];
    assign gyroFieldByteMid = bufOut[39:32];
    assign gyroFieldByteLo = bufOut[31:24];
    assign accelFieldByteHi = bufOut[23:16];
    assign accelFieldByteMid = bufOut[15:8];
    assign accelFieldByteLo = bufOut[7:0];

endmodule

// File: pkg/iou_map.vh
// register map, field positions, unit codes and scaling constants of the
// output unit datapath; included by the datapath top module only
`ifndef IOU_MAP_VH
`define IOU_MAP_VH

// register byte offsets on the apb slave
`define IOU_OFS_CTRL 12'h000
`define IOU_OFS_BIASK 12'h004
`define IOU_OFS_SCALEK 12'h008
`define IOU_OFS_STATUS 12'h00C
`define IOU_OFS_INTEG 12'h010

// reset values and the control register write mask
`define IOU_CTRL_RST 32'h0000_0000
`define IOU_COEF_RST 16'h0000
`define IOU_CTRL_MASK 32'h0001_FFFF

// control register fields
`define IOU_F_GUNIT 1:0
`define IOU_F_AUNIT 2
`define IOU_F_RANGE 5:3
`define IOU_F_CFEN 6
`define IOU_F_CORNER 8:7
`define IOU_F_BIASEN 9
`define IOU_F_SCALEEN 10
`define IOU_F_GLPFEN 11
`define IOU_F_GLPFSH 15:12
`define IOU_F_CSRC 16

// status register fields
`define IOU_S_OVR 0
`define IOU_S_BUSY 1
`define IOU_S_FULL 2

// gyro output units
`define IOU_GU_RATE 2'h0
`define IOU_GU_INCR 2'h1
`define IOU_GU_AVG 2'h2
`define IOU_GU_INTEG 2'h3

// accelerometer output units
`define IOU_AU_ACCEL 1'h0
`define IOU_AU_VEL 1'h1

// accelerometer range codes
`define IOU_RNG_2G 3'h0
`define IOU_RNG_5G 3'h1
`define IOU_RNG_10G 3'h2
`define IOU_RNG_30G 3'h3
`define IOU_RNG_80G 3'h4

// velocity right shift per range, from the 2g weight of 2^-24
`define IOU_VSH_2G 3'h0
`define IOU_VSH_5G 3'h1
`define IOU_VSH_10G 3'h2
`define IOU_VSH_30G 3'h3
`define IOU_VSH_80G 3'h5
// acceleration field needs one more shift than velocity (input 2^-22 g)
`define IOU_ASH_EXTRA 3'h1

// compensation filter corner codes and their coefficient shifts
`define IOU_FC_0P001 2'h0
`define IOU_FC_0P01 2'h1
`define IOU_FC_5HZ 2'h2
`define IOU_SH_0P001 5'h12
`define IOU_SH_0P01 5'h0F
`define IOU_SH_5HZ 5'h06

// 128/2000 and 4*9.80665/2000 in 16 fractional bits
`define IOU_K_ANGLE 17'h01062
`define IOU_K_VEL 17'h00505
`define IOU_K_FRAC 5'h10
`define IOU_COEF_FRAC 5'h0F
`define IOU_RXA_FRAC 5'h16

`endif

// File: verilog/iou_divider.v
// unsigned restoring divider, one quotient bit per clock
// assumes start is a one-cycle pulse given only while busy is low
`timescale 1ns/1ps
module iou_divider #(
    parameter NW = 36,
    parameter DW = 12
) (
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // request
    input wire start,
    input wire [NW-1:0] numer,
    input wire [DW-1:0] denom,
    // answer
    output reg busy,
    output reg done,
    output reg [NW-1:0] quot
);

    localparam CW = $clog2(NW + 1);
    localparam [CW-1:0] STEPS = NW;
    localparam [CW-1:0] ONE = 1;

    reg [NW-1:0] numReg;
    reg [DW-1:0] denReg;
    reg [DW:0] remReg;
    reg [CW-1:0] cntReg;
    wire [DW:0] remShift;
    wire remFits;

    // next partial remainder and the trial subtraction
    assign remShift = {remReg[DW-1:0], numReg[NW-1]};
    assign remFits = remShift >= {1'b0, denReg};

    // one shift-subtract step per clock until all bits are done
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            numReg <= {NW{1'b0}};
            denReg <= {DW{1'b0}};
            remReg <= {(DW+1){1'b0}};
            cntReg <= {CW{1'b0}};
            quot <= {NW{1'b0}};
            busy <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (start && !busy)
            begin
                numReg <= numer;
                denReg <= denom;
                remReg <= {(DW+1){1'b0}};
                cntReg <= STEPS;
                busy <= 1'b1;
            end
            else if (busy)
            begin
                numReg <= {numReg[NW-2:0], 1'b0};
                remReg <= remFits ? remShift - {1'b0, denReg} : remShift;
                quot <= {quot[NW-2:0], remFits};
                cntReg <= cntReg - ONE;
                if (cntReg == ONE)
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end

endmodule

// File: verilog/iou_pair_buffer.v
// two-entry buffer with valid and ready on both sides
// both outputs are registered so the receiver sees flip-flops only
`timescale 1ns/1ps
module iou_pair_buffer #(
    parameter W = 48
) (
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // filling side
    input wire inValid,
    output reg inReady,
    input wire [W-1:0] inData,
    // draining side
    output reg outValid,
    input wire outReady,
    output reg [W-1:0] outData
);

    reg tailValid;
    reg [W-1:0] tailData;
    wire push;
    wire pop;

    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // head holds the oldest word, tail the second; ready drops when full
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            outValid <= 1'b0;
            outData <= {W{1'b0}};
            tailValid <= 1'b0;
            tailData <= {W{1'b0}};
            inReady <= 1'b0;
        end
        else
        begin
            if (pop)
            begin
                if (tailValid)
                begin
                    outData <= tailData;
                    tailValid <= push;
                    tailData <= inData;
                end
                else
                begin
                    outValid <= push;
                    outData <= inData;
                end
            end
            else if (push)
            begin
                if (!outValid)
                begin
                    outValid <= 1'b1;
                    outData <= inData;
                end
                else
                begin
                    tailValid <= 1'b1;
                    tailData <= inData;
                end
            end
            // full only when both slots hold a word after this edge
            inReady <= !((tailValid && !pop) || (push && outValid && !pop));
        end
    end

endmodule

// File: testbench/iou_datapath_monitor.sv
// port checker for the output unit datapath
// assumes one clock, async active-low rst_n
`timescale 1ns/1ps
module iou_datapath_monitor (
    // clock and reset
    input logic sys_clk,
    input logic rst_n,
    // apb
    input logic [11:0] paddr,
    input logic psel,
    input logic penable,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    // field stream
    input logic latchStrobe,
    input logic fieldValid,
    input logic fieldReady,
    input logic [7:0] gyroFieldByteLo,
    input logic [7:0] accelFieldByteHi
);
    // ********************
    // properties
    // ********************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire setup = psel && !penable;
    // zero wait states
    a_ready_up: assert property ($past(rst_n) |-> pready)
        else $error("pready low");
    a_err_unmapped: assert property (setup && paddr > 12'h010
        |=> pslverr && prdata == 32'h0) else $error("unmapped not refused");
    a_ok_mapped: assert property (setup && paddr <= 12'h010
        && paddr[1:0] == 2'h0 |=> !pslverr) else $error("mapped refused");
    a_access_ready: assert property (psel && penable
        |-> pready ##1 $stable(prdata)) else $error("read data moved");
    a_hold_word: assert property (fieldValid && !fieldReady
        |=> fieldValid && $stable(gyroFieldByteLo)
        && $stable(accelFieldByteHi)) else $error("word dropped in stall");
    // compute takes ~39 cycles after a latch
    a_no_early: assert property (latchStrobe && !fieldValid
        |=> !fieldValid [*8]) else $error("word too early");
    a_valid_soon: assert property (latchStrobe && fieldReady
        && !fieldValid |-> ##[30:50] fieldValid) else $error("word late");
    a_quiet_reset: assert property ($rose(rst_n)
        |-> !fieldValid && !pslverr && prdata == 32'h0)
        else $error("outputs not cleared");
    c_latch: cover property (latchStrobe && fieldReady);
    c_stall: cover property (fieldValid && !fieldReady);
    c_refuse: cover property (setup && paddr > 12'h010);
endmodule

bind iou_datapath iou_datapath_monitor u_mon (.*);

// File: testbench/iou_field_sink.sv
// field receiver standing in for the host
// assumes stall from the bench
`timescale 1ns/1ps
module iou_field_sink (
    // clock and reset
    input logic sys_clk,
    input logic rst_n,
    // field stream
    input logic fieldValid,
    output logic fieldReady,
    input logic [47:0] word,
    // bench side
    input logic stall,
    output logic [47:0] lastWord,
    output int takenCount
);
    // take a word on valid and ready; ready lags stall by a cycle
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fieldReady <= 1'b0;
            lastWord <= 48'h0;
            takenCount <= 0;
        end
        else
        begin
            fieldReady <= !stall;
            if (fieldValid && fieldReady)
            begin
                lastWord <= word;
                takenCount <= takenCount + 1;
            end
        end
    end
endmodule

// File: testbench/iou_datapath_tb_top.sv
// bench: apb setup, samples, latches, field compare
// assumes a 20 MHz clock; g and gyro filters stay off
`timescale 1ns/1ps
module iou_datapath_tb_top;
    logic sys_clk = 0;
    logic rst_n = 0;
    logic [11:0] paddr = 0;
    logic psel = 0, penable = 0, pwrite = 0, err;
    logic [31:0] pwdata = 0, rd;
    logic sampleStrobe = 0, latchStrobe = 0, stall = 0;
    logic [23:0] gyroSample = 0, accelSample = 0;
    logic [39:0] integAcc = 0;
    wire [31:0] prdata;
    wire pready, pslverr, fieldValid, fieldReady;
    wire [7:0] gHi, gMid, gLo, aHi, aMid, aLo;
    wire [47:0] lastWord;
    int takenCount, n0, errors = 0, samples_checked = 0;
    int vsh [5] = '{0, 1, 2, 3, 5};

    iou_datapath DUT (.*, .pstrb(4'hF), .inclSample(24'h0),
        .gyroFieldByteHi(gHi),
        .gyroFieldByteMid(gMid), .gyroFieldByteLo(gLo),
        .accelFieldByteHi(aHi), .accelFieldByteMid(aMid),
        .accelFieldByteLo(aLo));
    iou_field_sink u_sink (.*, .word({gHi, gMid, gLo, aHi, aMid, aLo}));

    initial forever #25 sys_clk = ~sys_clk;

    // ********************
    // tasks
    // ********************
    task chk(input string what, input logic [47:0] got, exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer, held until pready
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        for (int n = 0; n < 50 && pready !== 1'b1; n++)
            @(posedge sys_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // integAcc tracks the wrapping integrator
    task smp(input logic [23:0] g, a);
        @(posedge sys_clk);
        sampleStrobe <= 1'b1;
        gyroSample <= g;
        accelSample <= a;
        integAcc = integAcc + {{16{g[23]}}, g} * 40'd4194;
        @(posedge sys_clk);
        sampleStrobe <= 1'b0;
    endtask

    // latch, then room for the compute
    task pulse;
        @(posedge sys_clk);
        latchStrobe <= 1'b1;
        @(posedge sys_clk);
        latchStrobe <= 1'b0;
        repeat (45) @(posedge sys_clk);
    endtask

    task lat(input string what, input logic [47:0] exp);
        n0 = takenCount;
        pulse();
        for (int n = 0; n < 100 && takenCount == n0; n++)
            @(posedge sys_clk);
        chk(what, lastWord, exp);
    endtask

    task finish_test;
        if (errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ********************
    // tests
    // ********************
    initial
    begin
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        apb(1, 12'h000, 32'hFFFF_FFFF);
        apb(0, 12'h000, 0);
        chk("ctrl", rd, 32'h0001_FFFF);
        apb(0, 12'h020, 0);
        chk("unmapped", {err, rd}, {1'b1, 32'h0});
        apb(1, 12'h000, 32'h1);
        repeat (4) smp(24'h004000, 24'h400000);
        lat("incr", {24'd4194, 24'h200000});
        apb(1, 12'h000, 32'h26);
        for (int i = 1; i < 5; i++)
            smp(24'(i * 100), 24'h400000);
        lat("avg", {24'd250, 24'd10280});
        for (int i = 0; i < 5; i++)
        begin
            apb(1, 12'h000, 32'(i << 3));
            smp(24'hFFF000, 24'h400000);
            lat("accel", {24'hFFF000, 24'(24'h400000 >> (vsh[i] + 1))});
            apb(1, 12'h000, 32'(i << 3 | 4));
            smp(24'hFFF000, 24'h400000);
            lat("vel", {24'hFFF000, 24'(82240 >> vsh[i])});
        end
        // receiver stalls, two words wait
        apb(1, 12'h000, 32'h1);
        n0 = takenCount;
        stall <= 1'b1;
        smp(24'h004000, 24'h0);
        pulse();
        smp(24'h008000, 24'h0);
        pulse();
        chk("stalled", 48'(takenCount - n0), 48'h0);
        stall <= 1'b0;
        repeat (10) @(posedge sys_clk);
        chk("drained", 48'(takenCount - n0), 48'h2);
        chk("order", lastWord, {24'd2097, 24'h0});
        apb(1, 12'h000, 32'h3);
        repeat (20) smp(24'h7FFFFF, 24'h0);
        lat("integ", {integAcc[39:16], 24'h0});
        apb(0, 12'h010, 0);
        chk("integreg", rd[23:0], integAcc[39:16]);
        apb(1, 12'h004, 32'h4000);
        apb(1, 12'h000, 32'h200);
        smp(24'h300000, 24'h400000);
        lat("bias", {24'h100000, 24'h200000});
        finish_test();
    end

    // watchdog
    initial
    begin
        #1ms;
        errors++;
        finish_test();
    end
endmodule
